// ===== common/ptwd_pkg.sv
package ptwd_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned INDEX_W  = 8;
  localparam int unsigned ENTRIES  = 255;
  localparam int unsigned OP_MSB   = 15;
  localparam int unsigned OP_LSB   = 8;
  localparam int unsigned IDX_MSB  = 7;
  localparam int unsigned IDX_LSB  = 0;

  // ****************************************************************
  // Instruction groups (upper byte of the code)
  // ****************************************************************
  localparam logic [7:0] OP_RAM_ACC = 8'h87;
  localparam logic [7:0] OP_RAM_DEC = 8'h88;
  localparam logic [7:0] OP_NV_SPD  = 8'h8D;
  localparam logic [7:0] OP_NV_ACC  = 8'h8E;
  localparam logic [7:0] OP_NV_DEC  = 8'h8F;

  // Entry 0 is not a table; entry 255 is answered as a code error
  localparam logic [7:0] IDX_FIRST  = 8'h01;
  localparam logic [7:0] IDX_REFUSE = 8'hFF;

  // ****************************************************************
  // Response codes
  // ****************************************************************
  localparam logic [15:0] RESP_NORMAL   = 16'h0000;
  localparam logic [15:0] RESP_CODE_ERR = 16'h0001;
  localparam logic [15:0] RESP_SEL_ERR  = 16'h0002;
  localparam logic [15:0] RESP_RANGE    = 16'h0003;
  localparam logic [15:0] RESP_RESET    = 16'h0000;

  // ****************************************************************
  // Permitted setting ranges (binary values)
  // ****************************************************************
  localparam logic [15:0] SPEED_MIN = 16'h0000;
  localparam logic [15:0] SPEED_MAX = 16'h1770;
  localparam logic [15:0] TIME_MIN  = 16'h0000;
  localparam logic [15:0] TIME_MAX  = 16'h4E20;

  // Reset value for the working copy and read outputs; the retained copy has no reset
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef enum {
    FLD_RAM_ACC,
    FLD_RAM_DEC,
    FLD_NV_SPD,
    FLD_NV_ACC,
    FLD_NV_DEC
  } ptwd_field_e;

endpackage

// ===== common/ptwd_store_if.sv
`timescale 1ns/1ps
interface ptwd_store_if;
  logic                     wr_en;
  ptwd_pkg::ptwd_field_e    wr_field;
  logic [7:0]               wr_index;
  logic [15:0]              wr_data;
  logic [7:0]               rd_index;
  logic [15:0]              rd_speed;
  logic [15:0]              rd_acc;
  logic [15:0]              rd_dec;

  modport ctrl (
    output wr_en,
    output wr_field,
    output wr_index,
    output wr_data,
    output rd_index,
    input  rd_speed,
    input  rd_acc,
    input  rd_dec
  );

  modport store (
    input  wr_en,
    input  wr_field,
    input  wr_index,
    input  wr_data,
    input  rd_index,
    output rd_speed,
    output rd_acc,
    output rd_dec
  );
endinterface

// ===== src/ptwd_decoder.sv
`timescale 1ns/1ps
module ptwd_decoder (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [15:0] instruction_code_word,
  input  wire logic [15:0] write_data_word,
  input  wire logic        select_lock,
  output logic [15:0]      response_code_word,
  output logic             response_valid,
  input  wire logic [7:0]  read_index,
  output logic [15:0]      read_speed,
  output logic [15:0]      read_acc,
  output logic [15:0]      read_dec
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum {
    ST_IDLE,
    ST_CHECK,
    ST_DONE
  } ptwd_state_e;

  ptwd_state_e           state_q, state_d;
  logic [15:0]           code_q, code_d;
  logic [15:0]           data_q, data_d;
  logic [15:0]           resp_q, resp_d;
  logic                  rvld_q, rvld_d;
  logic                  wr_q, wr_d;
  ptwd_pkg::ptwd_field_e fld_q, fld_d;
  logic                  lock_meta_q, lock_q;
  logic                  lock_meta_d, lock_d;

  ptwd_store_if sif ();

  // ****************************************************************
  // Selection lock arrives from a pin: two flops first
  // ****************************************************************
  // Only the second flop is read; the first may be metastable
  always_comb begin
    lock_meta_d = select_lock;
    lock_d      = lock_meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_meta_q <= 1'b0;
      lock_q      <= 1'b0;
    end else begin
      lock_meta_q <= lock_meta_d;
      lock_q      <= lock_d;
    end
  end

  // ****************************************************************
  // Decode of the captured words
  // ****************************************************************
  logic [7:0]            op;
  logic [7:0]            idx;
  logic                  op_known;
  logic                  is_speed;
  logic                  in_range;
  logic [15:0]           chk_resp;
  logic                  chk_ok;
  ptwd_pkg::ptwd_field_e fld_dec;

  assign op  = code_q[ptwd_pkg::OP_MSB:ptwd_pkg::OP_LSB];
  assign idx = code_q[ptwd_pkg::IDX_MSB:ptwd_pkg::IDX_LSB];

  always_comb begin
    op_known = 1'b1;
    is_speed = 1'b0;
    fld_dec  = ptwd_pkg::FLD_RAM_ACC;
    case (op)
      ptwd_pkg::OP_RAM_ACC: fld_dec = ptwd_pkg::FLD_RAM_ACC;
      ptwd_pkg::OP_RAM_DEC: fld_dec = ptwd_pkg::FLD_RAM_DEC;
      ptwd_pkg::OP_NV_SPD: begin
        fld_dec  = ptwd_pkg::FLD_NV_SPD;
        is_speed = 1'b1;
      end
      ptwd_pkg::OP_NV_ACC: fld_dec = ptwd_pkg::FLD_NV_ACC;
      ptwd_pkg::OP_NV_DEC: fld_dec = ptwd_pkg::FLD_NV_DEC;
      default:             op_known = 1'b0;
    endcase
  end

  // Data is a plain binary number, compared as such
  always_comb begin
    if (is_speed) begin
      in_range = (data_q >= ptwd_pkg::SPEED_MIN) &&
                 (data_q <= ptwd_pkg::SPEED_MAX);
    end else begin
      in_range = (data_q >= ptwd_pkg::TIME_MIN) &&
                 (data_q <= ptwd_pkg::TIME_MAX);
    end
  end

  // ****************************************************************
  // Checks in priority order: code, entry, selection, range
  // ****************************************************************
  // Entry 255 is refused although the codes reach xxFF
  always_comb begin
    chk_resp = ptwd_pkg::RESP_NORMAL;
    chk_ok   = 1'b0;
    if (!op_known) begin
      chk_resp = ptwd_pkg::RESP_CODE_ERR;
    end else if (idx < ptwd_pkg::IDX_FIRST ||
                 idx >= ptwd_pkg::IDX_REFUSE) begin
      chk_resp = ptwd_pkg::RESP_CODE_ERR;
    end else if (lock_q) begin
      chk_resp = ptwd_pkg::RESP_SEL_ERR;
    end else if (!in_range) begin
      chk_resp = ptwd_pkg::RESP_RANGE;
    end else begin
      chk_resp = ptwd_pkg::RESP_NORMAL;
      chk_ok   = 1'b1;
    end
  end

  // ****************************************************************
  // Sequencer: accept, check, answer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    data_d  = data_q;
    resp_d  = resp_q;
    rvld_d  = 1'b0;
    wr_d    = 1'b0;
    fld_d   = fld_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          code_d  = instruction_code_word;
          data_d  = write_data_word;
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Verdict and store decision leave together
        fld_d   = fld_dec;
        resp_d  = chk_resp;
        wr_d    = chk_ok;
        rvld_d  = 1'b1;
        state_d = ST_DONE;
      end
      ST_DONE: begin
        // Store lands here, one cycle with the answer
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      code_q  <= ptwd_pkg::DATA_RESET;
      data_q  <= ptwd_pkg::DATA_RESET;
      resp_q  <= ptwd_pkg::RESP_RESET;
      rvld_q  <= 1'b0;
      wr_q    <= 1'b0;
      fld_q   <= ptwd_pkg::FLD_RAM_ACC;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
      data_q  <= data_d;
      resp_q  <= resp_d;
      rvld_q  <= rvld_d;
      wr_q    <= wr_d;
      fld_q   <= fld_d;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Store only when checks passed; refused writes never touch it
  assign sif.wr_en    = wr_q;
  assign sif.wr_field = fld_q;
  assign sif.wr_index = code_q[ptwd_pkg::IDX_MSB:ptwd_pkg::IDX_LSB];
  assign sif.wr_data  = data_q;
  assign sif.rd_index = read_index;

  ptwd_store u_store (
    .clk (clk),
    .rst (rst),
    .bus (sif.store)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ready is combinational so a waiting master is taken at once
  assign cmd_ready          = (state_q == ST_IDLE);
  assign response_code_word = resp_q;
  assign response_valid     = rvld_q;
  assign read_speed         = sif.rd_speed;
  assign read_acc           = sif.rd_acc;
  assign read_dec           = sif.rd_dec;

endmodule  // ptwd_decoder

// ===== src/ptwd_store.sv
`timescale 1ns/1ps
module ptwd_store (
  input wire logic    clk,
  input wire logic    rst,
  ptwd_store_if.store bus
);

  // ****************************************************************
  // Retained copy: no reset, survives a drive reset
  // ****************************************************************
  logic [15:0] nv_spd_q [1:255];
  logic [15:0] nv_acc_q [1:255];
  logic [15:0] nv_dec_q [1:255];
  // ****************************************************************
  // Working copy: cleared by reset, overrides retained when set
  // ****************************************************************
  logic [15:0] ram_acc_q [1:255];
  logic [15:0] ram_dec_q [1:255];
  logic        ovr_acc_q [1:255];
  logic        ovr_dec_q [1:255];
  logic [15:0] rd_spd_q, rd_acc_q, rd_dec_q;
  logic [15:0] rd_spd_d, rd_acc_d, rd_dec_d;

  for (genvar i = 1; i <= 255; i++) begin : g_ent
    logic        hit;
    logic [15:0] nv_spd_d, nv_acc_d, nv_dec_d, ram_acc_d, ram_dec_d;
    logic        ovr_acc_d, ovr_dec_d;
    assign hit = bus.wr_en && (bus.wr_index == 8'(i));
    always_comb begin
      nv_spd_d  = nv_spd_q[i];
      nv_acc_d  = nv_acc_q[i];
      nv_dec_d  = nv_dec_q[i];
      ram_acc_d = ram_acc_q[i];
      ram_dec_d = ram_dec_q[i];
      ovr_acc_d = ovr_acc_q[i];
      ovr_dec_d = ovr_dec_q[i];
      if (hit) begin
        case (bus.wr_field)
          ptwd_pkg::FLD_RAM_ACC: begin
            ram_acc_d = bus.wr_data;
            ovr_acc_d = 1'b1;
          end
          ptwd_pkg::FLD_RAM_DEC: begin
            ram_dec_d = bus.wr_data;
            ovr_dec_d = 1'b1;
          end
          ptwd_pkg::FLD_NV_SPD: nv_spd_d = bus.wr_data;
          // Retained write also ends any working override
          ptwd_pkg::FLD_NV_ACC: begin
            nv_acc_d  = bus.wr_data;
            ovr_acc_d = 1'b0;
          end
          ptwd_pkg::FLD_NV_DEC: begin
            nv_dec_d  = bus.wr_data;
            ovr_dec_d = 1'b0;
          end
          default: ;
        endcase
      end
    end
    always_ff @(posedge clk) begin
      nv_spd_q[i] <= nv_spd_d;
      nv_acc_q[i] <= nv_acc_d;
      nv_dec_q[i] <= nv_dec_d;
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ram_acc_q[i] <= ptwd_pkg::DATA_RESET;
        ram_dec_q[i] <= ptwd_pkg::DATA_RESET;
        ovr_acc_q[i] <= 1'b0;
        ovr_dec_q[i] <= 1'b0;
      end else begin
        ram_acc_q[i] <= ram_acc_d;
        ram_dec_q[i] <= ram_dec_d;
        ovr_acc_q[i] <= ovr_acc_d;
        ovr_dec_q[i] <= ovr_dec_d;
      end
    end
  end

  // ****************************************************************
  // Effective values of one entry
  // ****************************************************************
  always_comb begin
    rd_spd_d = ptwd_pkg::DATA_RESET;
    rd_acc_d = ptwd_pkg::DATA_RESET;
    rd_dec_d = ptwd_pkg::DATA_RESET;
    if (bus.rd_index != 8'h00) begin
      rd_spd_d = nv_spd_q[bus.rd_index];
      rd_acc_d = ovr_acc_q[bus.rd_index] ? ram_acc_q[bus.rd_index]
                                         : nv_acc_q[bus.rd_index];
      rd_dec_d = ovr_dec_q[bus.rd_index] ? ram_dec_q[bus.rd_index]
                                         : nv_dec_q[bus.rd_index];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_spd_q <= ptwd_pkg::DATA_RESET;
      rd_acc_q <= ptwd_pkg::DATA_RESET;
      rd_dec_q <= ptwd_pkg::DATA_RESET;
    end else begin
      rd_spd_q <= rd_spd_d;
      rd_acc_q <= rd_acc_d;
      rd_dec_q <= rd_dec_d;
    end
  end

  assign bus.rd_speed = rd_spd_q;
  assign bus.rd_acc   = rd_acc_q;
  assign bus.rd_dec   = rd_dec_q;

endmodule  // ptwd_store

// ===== tb/ptwd_decoder_asserts.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder port checker
// ****************************************************************
module ptwd_decoder_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [15:0] instruction_code_word,
  input wire logic [15:0] write_data_word,
  input wire logic        select_lock,
  input wire logic [15:0] response_code_word,
  input wire logic        response_valid,
  input wire logic [7:0]  read_index,
  input wire logic [15:0] read_speed,
  input wire logic [15:0] read_acc,
  input wire logic [15:0] read_dec
);
  logic        take;
  logic        good;
  logic [15:0] lim;
  logic [7:0]  op;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  assign op   = instruction_code_word[15:8];
  assign take = cmd_valid && cmd_ready;
  assign good = op inside {8'h87, 8'h88, 8'h8D, 8'h8E, 8'h8F} &&
                instruction_code_word[7:0] != 8'h00 &&
                instruction_code_word[7:0] != 8'hFF;
  // Speed has its own ceiling, all times share one
  assign lim  = (op == 8'h8D) ? ptwd_pkg::SPEED_MAX : ptwd_pkg::TIME_MAX;

  AST_READY: assert property (take |=> !cmd_ready [*2] ##1 cmd_ready)
    else $error("ready not low for two cycles after accept");
  AST_ANSWER: assert property (take |=> !response_valid ##1
    response_valid ##1 !response_valid)
    else $error("response pulse not two cycles after accept");
  AST_HOLD: assert property (!response_valid |->
    $stable(response_code_word))
    else $error("response word moved without pulse");
  AST_BADCODE: assert property (take && !good |-> ##2
    response_code_word == ptwd_pkg::RESP_CODE_ERR)
    else $error("bad code not answered with 1");
  AST_LOCKED: assert property (take && good && select_lock &&
    $past(select_lock) && $past(select_lock, 2) |-> ##2
    response_code_word == ptwd_pkg::RESP_SEL_ERR)
    else $error("locked selection not answered with 2");
  AST_RANGE: assert property (take && good && !select_lock &&
    !$past(select_lock) && !$past(select_lock, 2) &&
    write_data_word > lim |-> ##2
    response_code_word == ptwd_pkg::RESP_RANGE)
    else $error("out of range value not answered with 3");
  AST_NORMAL: assert property (take && good && !select_lock &&
    !$past(select_lock) && !$past(select_lock, 2) &&
    write_data_word <= lim |-> ##2
    response_code_word == ptwd_pkg::RESP_NORMAL)
    else $error("good write not answered with 0");
  AST_RD_ZERO: assert property (read_index == 8'h00 |=>
    read_speed == 16'h0000 && read_acc == 16'h0000 &&
    read_dec == 16'h0000)
    else $error("entry zero does not read zeros");
endmodule // ptwd_decoder_asserts

bind ptwd_decoder ptwd_decoder_asserts u_chk (.clk, .rst, .cmd_valid,
  .cmd_ready, .instruction_code_word, .write_data_word, .select_lock,
  .response_code_word, .response_valid, .read_index, .read_speed,
  .read_acc, .read_dec);

// ===== tb/ptwd_master_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Fieldbus master model
// ****************************************************************
module ptwd_master_model (
  input  wire logic        clk,
  input  wire logic        cmd_ready,
  input  wire logic        response_valid,
  input  wire logic [15:0] response_code_word,
  output logic             cmd_valid,
  output logic [15:0]      instruction_code_word,
  output logic [15:0]      write_data_word
);
  initial begin
    cmd_valid             = 1'b0;
    instruction_code_word = 16'h0000;
    write_data_word       = 16'h0000;
  end

  // Whole 16-bit code and binary value, held until taken
  task automatic issue(input logic [15:0] code, input logic [15:0] data,
                       input int gap, output logic [15:0] resp);
    int n;
    repeat (gap) @(posedge clk);
    n = 0;
    cmd_valid             <= 1'b1;
    instruction_code_word <= code;
    write_data_word       <= data;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 8);
    // Released words inverted so stale values never pass
    cmd_valid             <= 1'b0;
    instruction_code_word <= ~code;
    write_data_word       <= ~data;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (response_valid !== 1'b1 && n < 8);
    // A missing answer must not pass on a stale word
    resp = (response_valid === 1'b1) ? response_code_word : 16'hXXXX;
  endtask
endmodule // ptwd_master_model

// ===== tb/tb_point_table_write_cmd_decoder.sv
`timescale 1ns/1ps
module tb_point_table_write_cmd_decoder;
  logic        clk;
  logic        rst;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        select_lock;
  logic        response_valid;
  logic [15:0] instruction_code_word;
  logic [15:0] write_data_word;
  logic [15:0] response_code_word;
  logic [7:0]  read_index;
  logic [15:0] read_speed;
  logic [15:0] read_acc;
  logic [15:0] read_dec;
  int          fail_count;
  int          compares;

  ptwd_decoder DUT (.clk, .rst, .cmd_valid, .cmd_ready,
    .instruction_code_word, .write_data_word, .select_lock,
    .response_code_word, .response_valid, .read_index, .read_speed,
    .read_acc, .read_dec);
  ptwd_master_model u_m (.clk, .cmd_ready, .response_valid,
    .response_code_word, .cmd_valid, .instruction_code_word,
    .write_data_word);

  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    select_lock = 1'b0;
    read_index  = 8'h00;
    fail_count  = 0;
    compares    = 0;
  end
  always #5 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim();
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic wr(logic [15:0] code, logic [15:0] data, logic [15:0] exp,
                    int gap = 0);
    logic [15:0] r;
    u_m.issue(code, data, gap, r);
    chk("response", r, exp);
  endtask

  task automatic rd(logic [7:0] idx);
    @(posedge clk);
    read_index <= idx;
    repeat (2) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_store();
    wr(16'h8D01, 16'h1770, ptwd_pkg::RESP_NORMAL);
    wr(16'h8E01, 16'h0102, ptwd_pkg::RESP_NORMAL);
    wr(16'h8F01, 16'h0203, ptwd_pkg::RESP_NORMAL);
    rd(8'h01);
    chk("speed", read_speed, 16'h1770);
    chk("acc", read_acc, 16'h0102);
    chk("dec", read_dec, 16'h0203);
    wr(16'h8701, 16'h4E20, ptwd_pkg::RESP_NORMAL);
    wr(16'h88FE, 16'h0011, ptwd_pkg::RESP_NORMAL);
    wr(16'h8DFE, 16'h0005, ptwd_pkg::RESP_NORMAL);
    rd(8'h01);
    chk("acc", read_acc, 16'h4E20);
    chk("dec", read_dec, 16'h0203);
    rd(8'hFE);
    chk("dec", read_dec, 16'h0011);
    chk("speed", read_speed, 16'h0005);
  endtask

  task automatic t_power();
    do_reset();
    rd(8'h01);
    chk("speed", read_speed, 16'h1770);
    chk("acc", read_acc, 16'h0102);
    chk("dec", read_dec, 16'h0203);
    rd(8'h00);
    chk("speed", read_speed, 16'h0000);
    chk("acc", read_acc, 16'h0000);
    chk("dec", read_dec, 16'h0000);
  endtask

  task automatic t_codes();
    logic [15:0] bad [6];
    bad = '{16'h8601, 16'h8700, 16'h87FF, 16'h9001, 16'h8D00, 16'h8DFF};
    foreach (bad[i])
      wr(bad[i], 16'h0007, ptwd_pkg::RESP_CODE_ERR);
    rd(8'h01);
    chk("speed", read_speed, 16'h1770);
  endtask

  task automatic t_lock();
    @(posedge clk);
    select_lock <= 1'b1;
    repeat (3) @(posedge clk);
    wr(16'h8D01, 16'h0001, ptwd_pkg::RESP_SEL_ERR);
    wr(16'h9001, 16'h0001, ptwd_pkg::RESP_CODE_ERR);
    select_lock <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h01);
    chk("speed", read_speed, 16'h1770);
  endtask

  task automatic t_range();
    wr(16'h8D01, 16'h1771, ptwd_pkg::RESP_RANGE, 4);
    wr(16'h8E01, 16'h4E21, ptwd_pkg::RESP_RANGE);
    wr(16'h8701, 16'hFFFF, ptwd_pkg::RESP_RANGE);
    wr(16'h8F01, 16'h4E21, ptwd_pkg::RESP_RANGE, 2);
    rd(8'h01);
    chk("speed", read_speed, 16'h1770);
    chk("acc", read_acc, 16'h0102);
    chk("dec", read_dec, 16'h0203);
    wr(16'h8801, 16'h4E20, ptwd_pkg::RESP_NORMAL);
    rd(8'h01);
    chk("dec", read_dec, 16'h4E20);
    // Retained write takes over from the working copy
    wr(16'h8F01, 16'h0304, ptwd_pkg::RESP_NORMAL);
    rd(8'h01);
    chk("dec", read_dec, 16'h0304);
  endtask

  initial begin
    do_reset();
    t_store();
    t_power();
    t_codes();
    t_lock();
    t_range();
    end_sim();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule // tb_point_table_write_cmd_decoder
